// [mmx_consts.vh]
`ifndef MMX_CONSTS_VH
`define MMX_CONSTS_VH

// Register byte addresses
`define A_CTRL      12'h000
`define A_INSTR     12'h004
`define A_PC        12'h008
`define A_PSW       12'h00C
`define A_SSW       12'h010
`define A_STAT      12'h014
`define A_MASK      12'h018
`define A_TRAP_PC   12'h01C
`define A_TRAP_LO   12'h020
`define A_TRAP_HI   12'h024
`define GPR_BASE6   6'h01
`define FPR_BASE5   5'h01

// Opcode bytes
`define OP_MOVW     8'h84
`define OP_MOVWP    8'h10
`define OP_MOVWS    8'h2D
`define OP_MULD     8'h2A
`define OP_MULS     8'h28
`define OP_MULW     8'h98
`define OP_UNSIGNED_WORD_MULTIPLY_OP    8'h9A
`define OP_MULWUX   8'h9B

// Processor register selector values
`define SEL_PSW     4'h0
`define SEL_SSW     4'h1

// Field positions
`define PSW_CC      3:0
`define PSW_FF      7:4
`define SSW_USER    0
`define EV_DONE     0
`define EV_TRAP     1
`define EV_REFUSE   2

// Reset values
`define PSW_RST     32'h00000000
`define SSW_RST     32'h00000000

// FSM codes
`define ST_IDLE     2'b01
`define ST_EXEC     2'b10

`endif

// [float_multiplier.v]
`timescale 1ns/1ps
`default_nettype none
module float_multiplier #(
  parameter EW = 11,
  parameter MW = 52
) (
  input  wire [EW+MW:0] a,
  input  wire [EW+MW:0] b,
  output reg  [EW+MW:0] r,
  output reg  [3:0]     flags
);
  localparam PW = 2*MW+2;
  localparam [EW+2:0] BIAS = (1 << (EW-1)) - 1;
  localparam [EW+2:0] EMAX = (1 << EW) - 1;

  wire          sg  = a[EW+MW] ^ b[EW+MW];
  wire [EW-1:0] ea  = a[EW+MW-1:MW];
  wire [EW-1:0] eb  = b[EW+MW-1:MW];
  wire [MW-1:0] fa  = a[MW-1:0];
  wire [MW-1:0] fb  = b[MW-1:0];
  wire          za  = ~|ea;
  wire          zb  = ~|eb;
  wire          xa  = &ea;
  wire          xb  = &eb;
  wire          na  = xa & |fa;
  wire          nb  = xb & |fb;
  // Signalling NaN: quiet bit clear
  wire          sna = na & ~fa[MW-1];
  wire          snb = nb & ~fb[MW-1];

  wire [PW-1:0] p    = {{(MW+1){1'b0}}, 1'b1, fa} * {{(MW+1){1'b0}}, 1'b1, fb};
  wire          top  = p[PW-1];
  wire [MW-1:0] kept = top ? p[PW-2:MW+1] : p[PW-3:MW];
  wire          g    = top ? p[MW] : p[MW-1];
  wire          st   = top ? |p[MW-1:0] : |p[MW-2:0];
  wire          up   = g & (st | kept[0]);
  wire [MW:0]   rnd  = {1'b0, kept} + {{MW{1'b0}}, up};
  wire [EW+2:0] esum = {3'b000, ea} + {3'b000, eb} + {{(EW+2){1'b0}}, top}
                     + {{(EW+2){1'b0}}, rnd[MW]};
  // Biased result exponent; below one means underflow
  wire          unf  = esum <= BIAS;
  wire [EW+2:0] e    = esum - BIAS;
  wire          ovf  = ~unf & (e >= EMAX);

  // Flags: {invalid, overflow, underflow, inexact}
  // Denormal operands are flushed to zero to keep the datapath small
  always @* begin
    r     = {sg, {EW{1'b0}}, {MW{1'b0}}};
    flags = 4'h0;
    if (na | nb | (xa & zb) | (xb & za)) begin
      r     = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
      flags = {sna | snb | (xa & zb) | (xb & za), 3'b000};
    end else if (xa | xb) begin
      r = {sg, {EW{1'b1}}, {MW{1'b0}}};
    end else if (za | zb) begin
      r = {sg, {EW{1'b0}}, {MW{1'b0}}};
    end else if (ovf) begin
      r     = {sg, {EW{1'b1}}, {MW{1'b0}}};
      flags = 4'h5;
    end else if (unf) begin
      flags = 4'h3;
    end else begin
      r     = {sg, e[EW-1:0], rnd[MW-1:0]};
      flags = {3'b000, g | st};
    end
  end
endmodule // float_multiplier
`default_nettype wire

// [move_multiply_execute_unit.v]
`timescale 1ns/1ps
`default_nettype none
`include "mmx_consts.vh"

// Notes on behaviour
// - Register move copies source to destination; N from bit 31, Z on zero.
// - Register move opcode byte 10000100; source bits 7:4, destination 3:0.
// - Processor register write: selector 0 program status, 1 supervisor status.
// - Program status target loads flags from value; other targets clear flags.
// - Supervisor status write from user mode is ignored and raises no trap.
// - Processor register write opcode 00010000; selector 7:4, source 3:0.
// - Word to single float moves raw bits, no conversion, no trap.
// - Double multiply writes product, sets four float flags, may trap.
// - On float trap keep program counter and original destination value.
// - Single multiply writes product, sets four float flags, may trap.
// - Signed multiply keeps low word; V on overflow; N Z C cleared.
// - Signed multiply opcode 10011000; multiplier 7:4, destination 3:0.
// - Unsigned multiply keeps low word; V on overflow; others cleared.
// - Unsigned extended multiply writes 64-bit product to register pair.
// - Selector values 0 and 1 name the two status words, for processor register writes only.
module move_multiply_execute_unit (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] gpr_r [0:15];
  reg [63:0] fpr_r [0:15];
  reg [31:0] psw_r;
  reg [31:0] ssw_r;
  reg [31:0] pc_r;
  reg [31:0] trap_pc_r;
  reg [63:0] trap_dest_r;
  reg [15:0] instr_r;
  reg [3:0]  trap_en_r;
  reg [2:0]  stat_r;
  reg [2:0]  mask_r;
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  integer    i;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [7:0]  opc  = instr_r[15:8];
  wire [3:0]  f1   = instr_r[7:4];
  wire [3:0]  f2   = instr_r[3:0];
  wire [31:0] src  = gpr_r[f1];
  wire [31:0] dst  = gpr_r[f2];
  wire [3:0]  pl   = {1'b0, instr_r[2:1], 1'b0};
  wire [3:0]  ph   = pl + 4'h1;
  wire        exec = state_r[1];
  wire        user = ssw_r[`SSW_USER];

  wire signed [63:0] sprod = $signed({{32{dst[31]}}, dst}) * $signed({{32{src[31]}}, src});
  wire [63:0] uprod  = {32'h00000000, dst} * {32'h00000000, src};
  wire [63:0] uxprod = {32'h00000000, src} * {32'h00000000, gpr_r[pl]};
  wire        s_ovf  = sprod[63:32] != {32{sprod[31]}};
  wire        u_ovf  = |uprod[63:32];
  wire        ux_ovf = |uxprod[63:32];

  // ----------------------------------------
  // Floating multipliers
  // ----------------------------------------
  wire [63:0] d_res;
  wire [3:0]  d_fl;
  wire [31:0] s_res;
  wire [3:0]  s_fl;

  float_multiplier #(.EW(11), .MW(52)) u_dmul (
    .a     (fpr_r[f2]),
    .b     (fpr_r[f1]),
    .r     (d_res),
    .flags (d_fl)
  );

  float_multiplier #(.EW(8), .MW(23)) u_smul (
    .a     (fpr_r[f2][31:0]),
    .b     (fpr_r[f1][31:0]),
    .r     (s_res),
    .flags (s_fl)
  );

  wire       is_muld = opc == `OP_MULD;
  wire       is_fp   = is_muld | (opc == `OP_MULS);
  wire [3:0] fl      = is_muld ? d_fl : s_fl;
  // Trap when a raised flag has its enable set
  wire       fp_trap = exec & is_fp & |(fl & trap_en_r);
  wire       refuse  = exec & (opc == `OP_MOVWP) & (f1 == `SEL_SSW) & user;
  wire [2:0] ev      = {refuse, fp_trap, exec};

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire acc   = psel & penable & pready;
  wire wr    = acc & pwrite;
  wire rd    = acc & ~pwrite;
  wire gpr_h = paddr[11:6] == `GPR_BASE6;
  wire fpr_h = paddr[11:7] == `FPR_BASE5;
  wire [3:0] gi = paddr[5:2];
  wire [3:0] fi = paddr[6:3];

  reg [31:0] rdata_nxt;
  reg        hit_nxt;

  always @* begin
    hit_nxt   = 1'b1;
    rdata_nxt = 32'h00000000;
    if (gpr_h) begin
      rdata_nxt = gpr_r[gi];
    end else if (fpr_h) begin
      rdata_nxt = paddr[2] ? fpr_r[fi][63:32] : fpr_r[fi][31:0];
    end else begin
      case (paddr)
        `A_CTRL:    rdata_nxt = {28'h0000000, trap_en_r};
        `A_INSTR:   rdata_nxt = {15'h0000, exec, instr_r};
        `A_PC:      rdata_nxt = pc_r;
        `A_PSW:     rdata_nxt = psw_r;
        `A_SSW:     rdata_nxt = ssw_r;
        `A_STAT:    rdata_nxt = {29'h00000000, stat_r};
        `A_MASK:    rdata_nxt = {29'h00000000, mask_r};
        `A_TRAP_PC: rdata_nxt = trap_pc_r;
        `A_TRAP_LO: rdata_nxt = trap_dest_r[31:0];
        `A_TRAP_HI: rdata_nxt = trap_dest_r[63:32];
        default:    hit_nxt   = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // APB response
  // ----------------------------------------
  // One wait state keeps every bus output on a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= ~hit_nxt;
        prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Clear only the bits the read returned, so a later event is kept
  wire       stat_rd = rd & (paddr == `A_STAT);
  wire [2:0] stat_clr = stat_rd ? prdata[2:0] : 3'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 3'h0;
      mask_r <= 3'h0;
      irq    <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | ev;
      if (wr && paddr == `A_MASK)
        mask_r <= pwdata[2:0];
      irq <= |(stat_r & mask_r);
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  wire start = wr & (paddr == `A_INSTR) & state_r[0];

  always @* begin
    case (state_r)
      `ST_IDLE: state_nxt = start ? `ST_EXEC : `ST_IDLE;
      `ST_EXEC: state_nxt = `ST_IDLE;
      default:  state_nxt = `ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_r <= `ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------
  // Register file and execution
  // ----------------------------------------
  // Bus writes and execution never meet: a bus transfer takes at
  // least two cycles and execution lasts one cycle after the start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        gpr_r[i] <= 32'h00000000;
        fpr_r[i] <= 64'h0000000000000000;
      end
      psw_r       <= `PSW_RST;
      ssw_r       <= `SSW_RST;
      pc_r        <= 32'h00000000;
      trap_pc_r   <= 32'h00000000;
      trap_dest_r <= 64'h0000000000000000;
      instr_r     <= 16'h0000;
      trap_en_r   <= 4'h0;
    end else if (exec) begin
      case (opc)
        `OP_MOVW: begin
          gpr_r[f2]     <= src;
          psw_r[`PSW_CC] <= {src[31], src == 32'h00000000, 2'b00};
        end
        `OP_MOVWP: begin
          if (f1 == `SEL_PSW) begin
            psw_r <= dst;
          end else begin
            psw_r[`PSW_CC] <= 4'h0;
            if (f1 == `SEL_SSW && !user)
              ssw_r <= dst;
          end
        end
        `OP_MOVWS: begin
          fpr_r[f2] <= {32'h00000000, src};
        end
        `OP_MULD, `OP_MULS: begin
          psw_r[`PSW_FF] <= fl;
          if (fp_trap) begin
            trap_pc_r   <= pc_r;
            trap_dest_r <= fpr_r[f2];
          end else if (is_muld) begin
            fpr_r[f2] <= d_res;
          end else begin
            fpr_r[f2] <= {32'h00000000, s_res};
          end
        end
        `OP_MULW: begin
          gpr_r[f2]      <= sprod[31:0];
          psw_r[`PSW_CC] <= {2'b00, s_ovf, 1'b0};
        end
        `OP_UNSIGNED_WORD_MULTIPLY_OP: begin
          gpr_r[f2]      <= uprod[31:0];
          psw_r[`PSW_CC] <= {2'b00, u_ovf, 1'b0};
        end
        `OP_MULWUX: begin
          // Bit 3 must be zero; other encodings fall through as no-ops
          if (!instr_r[3]) begin
            gpr_r[pl]      <= uxprod[31:0];
            gpr_r[ph]      <= uxprod[63:32];
            psw_r[`PSW_CC] <= {2'b00, ux_ovf, 1'b0};
          end
        end
        default: begin
        end
      endcase
    end else if (wr) begin
      if (gpr_h) begin
        gpr_r[gi] <= pwdata;
      end else if (fpr_h) begin
        if (paddr[2])
          fpr_r[fi][63:32] <= pwdata;
        else
          fpr_r[fi][31:0] <= pwdata;
      end else begin
        case (paddr)
          `A_CTRL:  trap_en_r <= pwdata[3:0];
          `A_INSTR: instr_r   <= state_r[0] ? pwdata[15:0] : instr_r;
          `A_PC:    pc_r      <= pwdata;
          `A_PSW:   psw_r     <= pwdata;
          `A_SSW:   ssw_r     <= pwdata;
          default: begin
          end
        endcase
      end
    end
  end

endmodule // move_multiply_execute_unit
`default_nettype wire

// [mmx_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module mmx_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // Bus answer timing
  // ---------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  chk_ready_late:   assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse:  assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_idle_quiet:   assert property (!psel |=> !pready)
    else $error("pready without select");
  chk_err_ready:    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (pready && paddr[11:9] != 3'h0 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok:    assert property (pready && paddr <= 12'h024 |-> !pslverr)
    else $error("mapped access refused");
  chk_write_zero:   assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
endmodule // mmx_checker

bind move_multiply_execute_unit mmx_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// [apb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        done,
  output var  logic [31:0] rdata,
  output var  logic        err
);
  // Released address and write data lines toggle so a stale value is never mistaken for a live one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      done    <= 1'b0;
      paddr   <= 12'h000;
      pwdata  <= 32'h0;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        psel    <= 1'b0;
        penable <= 1'b0;
        done    <= 1'b1;
        rdata   <= prdata;
        err     <= pslverr;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (req) begin
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wdata;
      end else begin
        paddr  <= ~paddr;
        pwdata <= ~pwdata;
      end
    end
  end
endmodule // apb_host_model
`default_nettype wire

// [tb_move_multiply_execute_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mmx_consts.vh"
module tb_move_multiply_execute_unit;
  logic        pclk, presetn, req, wr;
  logic [11:0] addr;
  logic [31:0] wdat;
  wire         psel, penable, pwrite, pready, pslverr, irq, done, err;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata, rdat;
  int          fails, checks, cycles;
  logic [31:0] tv [0:13][0:8];

  apb_host_model host_u (.pclk(pclk), .presetn(presetn), .req(req), .wr(wr), .addr(addr),
    .wdata(wdat), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .done(done),
    .rdata(rdat), .err(err));
  move_multiply_execute_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req  <= 1'b1;
    wr   <= w;
    addr <= a;
    wdat <= d;
    @(posedge pclk);
    req <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (done !== 1'b1 && n < 50);
    // A transfer that never answers is a mismatch, not a silent pass
    if (done !== 1'b1) begin
      fails++;
      $display("[ERR] %0t no answer at address %h", $time, a);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0);
    cmp(rdat & m, e);
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      $display("[ERR] %0t run limit reached", $time);
      results();
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    req     = 1'b0;
    wr      = 1'b0;
    addr    = 12'h000;
    wdat    = 32'h0;
    fails   = 0;
    checks  = 0;
    cycles  = 0;
    // Setup two writes, instruction, result place and value, flag value and mask
    tv[0]  = '{12'h04C, 32'h80000000, 12'h04C, 32'h80000000, 16'h8430, 12'h040, 32'h80000000, 8'h08, 8'hFF};
    tv[1]  = '{12'h054, 32'h0, 12'h054, 32'h0, 16'h8452, 12'h048, 32'h0, 8'h04, 8'hFF};
    tv[2]  = '{12'h048, 32'h00010000, 12'h050, 32'h00010000, 16'h9824, 12'h050, 32'h0, 8'h02, 8'hFF};
    tv[3]  = '{12'h048, 32'hFFFFFFFD, 12'h050, 32'h5, 16'h9824, 12'h050, 32'hFFFFFFF1, 8'h00, 8'hFF};
    tv[4]  = '{12'h048, 32'hFFFFFFFD, 12'h050, 32'h5, 16'h9A24, 12'h050, 32'hFFFFFFF1, 8'h02, 8'hFF};
    tv[5]  = '{12'h054, 32'h00010000, 12'h058, 32'h00030000, 16'h9B56, 12'h05C, 32'h3, 8'h02, 8'hFF};
    tv[6]  = '{12'h054, 32'h00010000, 12'h058, 32'h00030000, 16'h9B56, 12'h058, 32'h0, 8'h02, 8'hFF};
    tv[7]  = '{12'h044, 32'hA5, 12'h044, 32'hA5, 16'h1001, 12'h00C, 32'hA5, 8'hA5, 8'hFF};
    tv[8]  = '{12'h00C, 32'h3F, 12'h044, 32'h1, 16'h1021, 12'h010, 32'h0, 8'h30, 8'hFF};
    tv[9]  = '{12'h044, 32'h1234, 12'h044, 32'h1234, 16'h1011, 12'h010, 32'h1234, 8'h00, 8'h0F};
    tv[10] = '{12'h044, 32'h12345678, 12'h044, 32'h12345678, 16'h2D12, 12'h090, 32'h12345678, 8'h00, 8'hF0};
    tv[11] = '{12'h080, 32'h40000000, 12'h088, 32'h40400000, 16'h2801, 12'h088, 32'h40C00000, 8'h00, 8'hF0};
    tv[12] = '{12'h09C, 32'h3FF80000, 12'h0A4, 32'h40000000, 16'h2A34, 12'h0A4, 32'h40080000, 8'h00, 8'hF0};
    tv[13] = '{12'h0A8, 32'h3F800001, 12'h0B0, 32'h3F800001, 16'h2856, 12'h0B0, 32'h3F800002, 8'h10, 8'hF0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      xfer(1'b1, `A_PSW, 32'h0);
      xfer(1'b1, tv[i][0][11:0], tv[i][1]);
      xfer(1'b1, tv[i][2][11:0], tv[i][3]);
      xfer(1'b1, `A_INSTR, tv[i][4]);
      rdchk(tv[i][5][11:0], tv[i][6], 32'hFFFFFFFF);
      rdchk(`A_PSW, tv[i][7], tv[i][8]);
    end
    // Trap keeps the old destination; only the trap bit is unmasked
    rdchk(`A_STAT, 32'h1, 32'hFFFFFFFF);
    xfer(1'b1, `A_PSW, 32'h0);
    xfer(1'b1, `A_CTRL, 32'h8);
    xfer(1'b1, `A_MASK, 32'h2);
    xfer(1'b1, `A_PC, 32'h00001000);
    xfer(1'b1, 12'h0B8, 32'h7F800000);
    xfer(1'b1, `A_INSTR, 32'h2887);
    rdchk(12'h0B8, 32'h7F800000, 32'hFFFFFFFF);
    rdchk(`A_TRAP_PC, 32'h00001000, 32'hFFFFFFFF);
    rdchk(`A_TRAP_LO, 32'h7F800000, 32'hFFFFFFFF);
    rdchk(`A_PSW, 32'h80, 32'hF0);
    cmp({31'h0, irq}, 32'h1);
    rdchk(`A_STAT, 32'h3, 32'hFFFFFFFF);
    xfer(1'b1, `A_SSW, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    xfer(1'b1, `A_INSTR, 32'h1011);
    rdchk(`A_SSW, 32'h1, 32'hFFFFFFFF);
    cmp({31'h0, irq}, 32'h0);
    rdchk(`A_STAT, 32'h5, 32'hFFFFFFFF);
    xfer(1'b0, 12'h200, 32'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rdat, 32'h0);
    // Second reset in mid-run clears the status words
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`A_PSW, 32'h0, 32'hFFFFFFFF);
    rdchk(`A_SSW, 32'h0, 32'hFFFFFFFF);
    rdchk(`A_CTRL, 32'h0, 32'hFFFFFFFF);
    results();
  end
endmodule // tb_move_multiply_execute_unit
`default_nettype wire
